// [color_gate_defs.svh]
`ifndef COLOR_GATE_DEFS_SVH
`define COLOR_GATE_DEFS_SVH
// Register byte offsets on the Avalon-MM slave
`define CG_OFS_CTRL 4'h0
`define CG_OFS_FB_SIZE 4'h4
`define CG_OFS_COUNT 4'h8
`define CG_OFS_STATUS 4'hc
// Control register fields
`define CG_CTRL_DROP 0
`define CG_CTRL_CLAMP 1
`define CG_CTRL_RGBA 2
`define CG_CTRL_GEOM 3
`define CG_CTRL_SIGNED 4
`define CG_CTRL_W 5
// Reset values: discard off, RGBA on, clamping off
`define CG_CTRL_RST 5'h04
`define CG_FB_W_RST 16'h0100
`define CG_FB_H_RST 16'h0100
// Datapath widths
`define CG_COMP_W 32
`define CG_FIX_W 10
`define CG_COORD_W 16
`define CG_DEPTH_W 24
`define CG_INDEX_IN_W 24
`define CG_INDEX_W 16
`define CG_CNT_W 16
// Word carried through the buffer: kind, op, x, y, depth, rgba, index
`define CG_WORD_W 205
// Buffer depth in words
`define CG_FIFO_DEPTH 8
`define CG_LVL_W 4
`endif

// [color_gate_pkg.sv]
package color_gate_pkg;
  // Item carried on the input and output streams
  typedef enum logic [1:0] {
    KIND_PRIM = 2'h0,
    KIND_CMD = 2'h1,
    KIND_NONE = 2'h3
  } item_kind_e;
  // Framebuffer commands that travel in the primitive stream
  typedef enum logic [2:0] {
    OP_SUM_BUFFER = 3'h0,
    OP_BITMAP = 3'h1,
    OP_PIXEL_COPY = 3'h2,
    OP_PIXEL_DRAW = 3'h3,
    OP_CLEAR = 3'h4,
    OP_BUFFER_WIPE = 3'h5,
    OP_OTHER_A = 3'h6,
    OP_OTHER_B = 3'h7
  } pixel_op_e;
  // Where the vertex color came from
  typedef enum logic [1:0] {
    SRC_FLOAT = 2'h0,
    SRC_UBYTE = 2'h1,
    SRC_USHORT = 2'h2,
    SRC_UINT = 2'h3
  } color_src_e;
endpackage

// [color_convert_raster_gate.sv]
// Summary of operation
// RULE_01 - Unclamped RGBA floats pass unchanged
// RULE_02 - Clamped RGBA may become normalized fixed point
// RULE_03 - Clamped components may stay floating point
// RULE_04 - Integer colors keep their top bits exactly
// RULE_05 - Color index rounds to nearest, wide enough
// RULE_06 - Each occupied grid square gets a depth
// RULE_07 - Fragment at lower-left corner, center half-offset
// RULE_08 - No fragments outside the framebuffer
// RULE_09 - Fragments go on to early tests
// RULE_10 - Only stream zero primitives proceed; the code filters by stream only while the geometry bit is set
// RULE_11 - Discard drops primitives after transform feedback
// RULE_12 - Discard clear forwards primitives normally
// RULE_13 - Discard ignores pixel and clear commands
// RULE_14 - Discard is one bit, resets false
// RULE_15 - Integer translation shifts fragments only
// RULE_16 - Transfers happen when valid and ready high
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "color_gate_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Flop-based FIFO with valid/ready on both sides
module cg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_reg [DEPTH]; // Storage entries
  logic [PW-1:0] wr_ptr_reg; // Next entry to fill
  logic [PW-1:0] rd_ptr_reg; // Oldest entry
  logic [LW-1:0] level_reg; // Words held
  logic push; // Word taken this edge
  logic pop; // Word given this edge

  assign in_ready = (level_reg != LW'(DEPTH));
  assign out_valid = (level_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign level = level_reg;
  assign push = in_valid && in_ready; // RULE_16
  assign pop = out_valid && out_ready; // RULE_16

  // One write port per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clock) begin
      if (push && (wr_ptr_reg == PW'(i))) begin
        mem_reg[i] <= in_data;
      end
    end
  end

  // Pointers wrap naturally; depth is a power of two
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + PW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + PW'(1);
      end
    end
  end

  // Fill level, exact so full and empty are honest
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      level_reg <= '0;
    end else if (push && !pop) begin
      level_reg <= level_reg + LW'(1);
    end else if (pop && !push) begin
      level_reg <= level_reg - LW'(1);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Final color conversion and pre-raster primitive gate
module color_convert_raster_gate
  import color_gate_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM register slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Items from the transform feedback stage
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [1:0] in_kind,
  input wire logic [2:0] in_op,
  input wire logic [1:0] in_stream,
  input wire logic [`CG_COORD_W-1:0] in_x,
  input wire logic [`CG_COORD_W-1:0] in_y,
  input wire logic [`CG_DEPTH_W-1:0] in_depth,
  input wire logic [1:0] in_color_src,
  input wire logic [`CG_COMP_W-1:0] in_red,
  input wire logic [`CG_COMP_W-1:0] in_green,
  input wire logic [`CG_COMP_W-1:0] in_blue,
  input wire logic [`CG_COMP_W-1:0] in_alpha,
  input wire logic [`CG_INDEX_IN_W-1:0] in_index,
  // Fragments and commands toward the early tests
  output logic out_valid,
  input wire logic out_ready,
  output logic [1:0] out_kind,
  output logic [2:0] out_op,
  output logic [`CG_COORD_W-1:0] out_x,
  output logic [`CG_COORD_W-1:0] out_y,
  output logic [`CG_COORD_W:0] out_center_x,
  output logic [`CG_COORD_W:0] out_center_y,
  output logic [`CG_DEPTH_W-1:0] out_depth,
  output logic [`CG_COMP_W-1:0] out_red,
  output logic [`CG_COMP_W-1:0] out_green,
  output logic [`CG_COMP_W-1:0] out_blue,
  output logic [`CG_COMP_W-1:0] out_alpha,
  output logic [`CG_INDEX_W-1:0] out_index
);
  localparam int DEPTH = `CG_FIFO_DEPTH;

  logic [`CG_CTRL_W-1:0] ctrl_reg; // Mode bits, discard included
  logic [31:0] fb_size_reg; // Height high, width low
  logic [`CG_CNT_W-1:0] drop_cnt_reg; // Primitives dropped
  logic [`CG_CNT_W-1:0] ign_cnt_reg; // Commands ignored
  logic waitrequest_reg; // High except in the answer cycle
  logic [31:0] readdata_reg; // Captured read answer
  logic in_ready_reg; // Room promised for the next edge
  logic out_valid_reg; // Output stage holds an item
  logic [`CG_WORD_W-1:0] out_word_reg; // Output stage contents
  logic raster_drop_enable; // Discard control bit
  logic accept; // Input item taken this edge
  logic keep; // Accepted item goes into the buffer
  logic ignorable; // Command is one that discard suppresses
  logic in_frame; // Square lies in the framebuffer
  logic stream_ok; // Stream zero, or any stream while the geometry bit is clear
  logic push; // Buffer write
  logic pop; // Buffer to output stage move
  logic fifo_in_ready; // Buffer has room
  logic fifo_out_valid; // Buffer has a word
  logic [`CG_WORD_W-1:0] fifo_out_data; // Oldest buffered word
  logic [`CG_LVL_W-1:0] fifo_level; // Buffered words
  logic [`CG_LVL_W:0] level_next; // Level after this edge
  logic [`CG_COMP_W-1:0] red_next; // Converted components
  logic [`CG_COMP_W-1:0] green_next;
  logic [`CG_COMP_W-1:0] blue_next;
  logic [`CG_COMP_W-1:0] alpha_next;
  logic [`CG_INDEX_W-1:0] index_next; // Rounded color index
  logic [`CG_WORD_W-1:0] word_next; // Packed buffer word
  logic acc_w; // Write completes this edge
  logic acc_r; // Read answer captured this edge
  logic drop_evt; // A primitive was dropped
  logic ign_evt; // A command was ignored

  assign raster_drop_enable = ctrl_reg[`CG_CTRL_DROP];

  // Unsigned normalized conversion to the color buffer width.
  // Bit replication keeps the integer source's top bits exact.
  function automatic logic [`CG_COMP_W-1:0] to_fixed(
    input logic [`CG_COMP_W-1:0] c,
    input color_src_e src,
    input logic sgn
  );
    logic [`CG_FIX_W-1:0] u;
    u = c[`CG_FIX_W-1:0];
    case (src)
      SRC_UBYTE: u = {c[7:0], c[7:6]}; // RULE_04
      SRC_USHORT: u = c[15:6]; // RULE_04
      SRC_UINT: u = c[31:22]; // RULE_04
      default: u = c[`CG_FIX_W-1:0];
    endcase
    // Signed formats spend one bit on sign, so they keep one fewer
    if (sgn) begin
      return {22'h000000, 1'b0, u[`CG_FIX_W-1:1]}; // RULE_02
    end
    return {22'h000000, u}; // RULE_02
  endfunction

  // Merge write data into a register by byte lanes
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Gate decision for the incoming item
  always_comb begin
    stream_ok = !ctrl_reg[`CG_CTRL_GEOM] || (in_stream == 2'h0); // RULE_10
    // Unsigned compare also rejects negative coordinates
    in_frame = (in_x < fb_size_reg[15:0]) && (in_y < fb_size_reg[31:16]); // RULE_08
    ignorable = (in_op <= 3'(OP_BUFFER_WIPE)); // RULE_13
    accept = in_valid && in_ready_reg; // RULE_16
    keep = 1'b0;
    case (item_kind_e'(in_kind))
      KIND_PRIM: begin
        // Drop sits after transform feedback consumed the item
        keep = stream_ok && !raster_drop_enable && in_frame; // RULE_11 RULE_12
      end
      KIND_CMD: begin
        keep = !(raster_drop_enable && ignorable); // RULE_13
      end
      default: begin
        keep = 1'b0;
      end
    endcase
    push = accept && keep && fifo_in_ready;
    drop_evt = accept && (item_kind_e'(in_kind) == KIND_PRIM) && !keep;
    ign_evt = accept && (item_kind_e'(in_kind) == KIND_CMD) && !keep;
  end

  // Final color processing
  always_comb begin
    red_next = in_red; // RULE_01
    green_next = in_green;
    blue_next = in_blue;
    alpha_next = in_alpha;
    // Float sources stay float even when clamped; conversion is optional
    if (ctrl_reg[`CG_CTRL_RGBA] && ctrl_reg[`CG_CTRL_CLAMP]
        && (color_src_e'(in_color_src) != SRC_FLOAT)) begin // RULE_03
      red_next = to_fixed(in_red, color_src_e'(in_color_src), ctrl_reg[`CG_CTRL_SIGNED]);
      green_next = to_fixed(in_green, color_src_e'(in_color_src), ctrl_reg[`CG_CTRL_SIGNED]);
      blue_next = to_fixed(in_blue, color_src_e'(in_color_src), ctrl_reg[`CG_CTRL_SIGNED]);
      alpha_next = to_fixed(in_alpha, color_src_e'(in_color_src), ctrl_reg[`CG_CTRL_SIGNED]);
    end
    // Round half up; saturate rather than wrap at the top
    if (&in_index[23:8] && in_index[7]) begin
      index_next = 16'hffff; // RULE_05
    end else begin
      index_next = in_index[23:8] + 16'(in_index[7]); // RULE_05
    end
    // One occupied square per primitive, carrying its depth
    word_next = {in_kind, in_op, in_x, in_y, in_depth, red_next, green_next,
                 blue_next, alpha_next, index_next}; // RULE_06
  end

  //////////////////////////////////////////////////////////////////////////////
  // Buffer between gate and early tests
  cg_fifo #(
    .WIDTH(`CG_WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(word_next),
    .out_valid(fifo_out_valid),
    .out_ready(!out_valid_reg || out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  assign pop = fifo_out_valid && (!out_valid_reg || out_ready); // RULE_16
  assign level_next = {1'b0, fifo_level} + {4'h0, push} - {4'h0, pop};

  // Ready is promised one edge ahead, so it must see the next level
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      in_ready_reg <= 1'b0;
    end else begin
      in_ready_reg <= (level_next < 5'(DEPTH)); // RULE_16
    end
  end

  // Output stage holds its word until the early tests take it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_valid_reg <= 1'b0;
      out_word_reg <= '0;
    end else if (pop) begin
      out_valid_reg <= 1'b1; // RULE_09
      out_word_reg <= fifo_out_data;
    end else if (out_ready) begin
      out_valid_reg <= 1'b0; // RULE_16
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then a one-cycle answer
  assign acc_w = write && !waitrequest_reg;
  assign acc_r = read && waitrequest_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      waitrequest_reg <= 1'b1;
    end else if (waitrequest_reg && (read || write)) begin
      waitrequest_reg <= 1'b0;
    end else begin
      waitrequest_reg <= 1'b1;
    end
  end

  // Read mux; unmapped offsets answer zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      readdata_reg <= 32'h00000000;
    end else if (acc_r) begin
      case (address)
        `CG_OFS_CTRL: readdata_reg <= {27'h0000000, ctrl_reg};
        `CG_OFS_FB_SIZE: readdata_reg <= fb_size_reg;
        `CG_OFS_COUNT: readdata_reg <= {ign_cnt_reg, drop_cnt_reg};
        `CG_OFS_STATUS: readdata_reg <= {23'h000000, in_ready_reg, out_valid_reg,
                                         3'h0, fifo_level};
        default: readdata_reg <= 32'h00000000;
      endcase
    end
  end

  // Control register; discard resets disabled
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_reg <= `CG_CTRL_RST; // RULE_14
    end else if (acc_w && (address == `CG_OFS_CTRL)) begin
      ctrl_reg <= `CG_CTRL_W'(merge({27'h0000000, ctrl_reg}, writedata, byteenable));
    end
  end

  // Framebuffer size; changing it mid-stream affects items not yet accepted
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fb_size_reg <= {`CG_FB_H_RST, `CG_FB_W_RST};
    end else if (acc_w && (address == `CG_OFS_FB_SIZE)) begin
      fb_size_reg <= merge(fb_size_reg, writedata, byteenable);
    end
  end

  // Event counters; a write clears, an event in the same cycle still counts
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      drop_cnt_reg <= '0;
      ign_cnt_reg <= '0;
    end else if (acc_w && (address == `CG_OFS_COUNT)) begin
      drop_cnt_reg <= 16'(drop_evt);
      ign_cnt_reg <= 16'(ign_evt);
    end else begin
      drop_cnt_reg <= drop_cnt_reg + 16'(drop_evt);
      ign_cnt_reg <= ign_cnt_reg + 16'(ign_evt);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops; center is x*2+1 in half units
  assign readdata = readdata_reg;
  assign waitrequest = waitrequest_reg;
  assign in_ready = in_ready_reg;
  assign out_valid = out_valid_reg;
  assign {out_kind, out_op, out_x, out_y, out_depth, out_red, out_green, out_blue,
          out_alpha, out_index} = out_word_reg;
  assign out_center_x = {out_word_reg[199:184], 1'b1}; // RULE_07 RULE_15
  assign out_center_y = {out_word_reg[183:168], 1'b1}; // RULE_07 RULE_15

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  unclamped_pass_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_01
    push && ctrl_reg[`CG_CTRL_RGBA] && !ctrl_reg[`CG_CTRL_CLAMP]
    |-> (word_next[143:112] == in_red) && (word_next[47:16] == in_alpha))
    else $error("unclamped color altered");

  float_keep_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_03
    push && (color_src_e'(in_color_src) == SRC_FLOAT) |-> word_next[111:80] == in_green)
    else $error("float color altered");

  byte_bits_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_04
    push && ctrl_reg[`CG_CTRL_RGBA] && ctrl_reg[`CG_CTRL_CLAMP] && !ctrl_reg[`CG_CTRL_SIGNED]
    && (color_src_e'(in_color_src) == SRC_UBYTE) |-> word_next[121:114] == in_red[7:0])
    else $error("byte color top bits lost");

  index_round_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_05
    push && !(&in_index[23:7]) |-> word_next[15:0] == in_index[23:8] + 16'(in_index[7]))
    else $error("index not rounded");

  outside_drop_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
    accept && (in_kind == 2'(KIND_PRIM)) && (in_x >= fb_size_reg[15:0])
    |-> !push ##1 (drop_cnt_reg == $past(drop_cnt_reg) + 16'h0001)
      || $past(acc_w))
    else $error("outside fragment forwarded");

  stream_drop_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_10
    accept && ctrl_reg[`CG_CTRL_GEOM] && (in_stream != 2'h0) |-> !push)
    else $error("nonzero stream forwarded");

  discard_prim_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_11
    accept && raster_drop_enable && (in_kind == 2'(KIND_PRIM)) |-> !push)
    else $error("primitive passed under discard");

  discard_cmd_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_13
    accept && raster_drop_enable && (in_kind == 2'(KIND_CMD)) && (in_op == 3'(OP_CLEAR))
    |-> !push)
    else $error("clear passed under discard");

  forward_prim_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_12
    accept && !raster_drop_enable && (in_kind == 2'(KIND_PRIM)) && in_frame
    && !ctrl_reg[`CG_CTRL_GEOM] |-> push)
    else $error("primitive lost without discard");

  drop_reset_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_14
    !$past(rst_n) |-> !raster_drop_enable)
    else $error("discard not reset");

  out_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_16
    out_valid_reg && !out_ready |=> out_valid_reg && $stable(out_word_reg))
    else $error("output changed while stalled");

  center_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_07
    out_valid_reg |-> (out_center_x >> 1) == {1'b0, out_x} && out_center_y[0])
    else $error("fragment center wrong");

  wait_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
    !waitrequest_reg |=> waitrequest_reg)
    else $error("answer longer than one cycle");

  drop_seen_c: cover property (@(posedge clock) disable iff (!rst_n) drop_evt);
  cmd_ignored_c: cover property (@(posedge clock) disable iff (!rst_n) ign_evt);
  fifo_full_c: cover property (@(posedge clock) disable iff (!rst_n) !fifo_in_ready);
  frag_out_c: cover property (@(posedge clock) disable iff (!rst_n)
    out_valid_reg && out_ready && (out_kind == 2'(KIND_PRIM)));
endmodule
`default_nettype wire

// [frag_sink.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Early-test side: accepts fragments, may stall or take every other cycle
module frag_sink (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic slow,
  input wire logic out_valid,
  input wire logic [238:0] item,
  output logic out_ready
);
  logic [238:0] got[$]; // Items in arrival order
  logic tick_reg = 1'b0; // Halves the accept rate when slow
  // Ready changes only just after an edge
  always @(posedge clock) begin
    tick_reg <= !tick_reg;
    out_ready <= rst_n && !stall && (!slow || tick_reg);
  end
  // Capture only on a joint valid/ready edge
  always @(posedge clock) begin
    if (rst_n && out_valid && out_ready) begin
      got.push_back(item);
    end
  end
endmodule
`default_nettype wire

// [color_convert_raster_gate_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "color_gate_defs.svh"
module color_convert_raster_gate_tb import color_gate_pkg::*;;
  logic clock, rst_n, read, write, in_valid, stall, slow, clamp, sgn;
  logic [3:0] address, byteenable;
  logic [31:0] writedata, readdata, in_red, in_green, in_blue, in_alpha;
  logic [31:0] out_red, out_green, out_blue, out_alpha;
  logic waitrequest, in_ready, out_valid, out_ready;
  logic [1:0] in_kind, in_stream, in_color_src, out_kind;
  logic [2:0] in_op, out_op;
  logic [15:0] in_x, in_y, out_x, out_y, out_index;
  logic [16:0] out_center_x, out_center_y;
  logic [23:0] in_depth, out_depth, in_index;
  logic [239:0] exp_q[$]; // Top bit marks a command: only kind and op compared
  int fail_count = 0, num_checks = 0, cycles = 0, i;
  color_convert_raster_gate color_convert_raster_gate_i (.clock, .rst_n, .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest, .in_valid, .in_ready, .in_kind,
    .in_op, .in_stream, .in_x, .in_y, .in_depth, .in_color_src, .in_red, .in_green, .in_blue,
    .in_alpha, .in_index, .out_valid, .out_ready, .out_kind, .out_op, .out_x, .out_y,
    .out_center_x, .out_center_y, .out_depth, .out_red, .out_green, .out_blue, .out_alpha,
    .out_index);
  frag_sink frag_sink_i (.clock, .rst_n, .stall, .slow, .out_valid, .out_ready,
    .item({out_kind, out_op, out_x, out_y, out_center_x, out_center_y, out_depth, out_red,
      out_green, out_blue, out_alpha, out_index}));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [238:0] e, logic [238:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  // Avalon access; a fresh edge first so strobes never toggle twice in one step
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d, logic [3:0] be);
    @(posedge clock);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !w;
    write <= w;
    // No fixed wait assumed; only the hang guard ends a stuck access
    do begin
      @(posedge clock);
    end while (waitrequest);
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    check("readdata", 239'(e), 239'(readdata));
  endtask
  // Expected final color, mirroring the control bits set by the bench
  function automatic logic [31:0] conv(logic [31:0] c, logic [1:0] s);
    logic [9:0] v;
    v = (s == 2'h1) ? {c[7:0], c[7:6]} : (s == 2'h2) ? c[15:6] : c[31:22];
    if (!clamp || s == 2'h0) return c;
    return sgn ? 32'({1'b0, v[9:1]}) : 32'(v);
  endfunction
  // One item upstream; pass says whether it should come out
  task automatic send(logic [1:0] k, logic [2:0] op, logic [1:0] st, logic [15:0] x,
    logic [15:0] y, logic [1:0] s, logic [31:0] c, logic pass);
    logic [15:0] ix;
    ix = (c[7] && c[23:8] != 16'hffff) ? c[23:8] + 16'h1 : c[23:8];
    @(posedge clock);
    in_valid <= 1'b1;
    in_kind <= k;
    in_op <= op;
    in_stream <= st;
    in_x <= x;
    in_y <= y;
    in_color_src <= s;
    in_red <= c;
    in_green <= ~c;
    in_blue <= {c[15:0], c[31:16]};
    in_alpha <= c ^ 32'h00ff00ff;
    in_index <= c[23:0];
    in_depth <= {x[11:0], y[11:0]};
    do begin
      @(posedge clock);
    end while (!in_ready);
    in_valid <= 1'b0;
    if (pass) exp_q.push_back({k == 2'h1, k, op, x, y, x, 1'b1, y, 1'b1, x[11:0], y[11:0],
      conv(c, s), conv(~c, s), conv({c[15:0], c[31:16]}, s), conv(c ^ 32'h00ff00ff, s), ix});
  endtask
  // Collect, then compare in order; a few spare cycles expose stray items
  task automatic drain();
    int n = 0;
    logic [239:0] e;
    logic [238:0] g;
    while (frag_sink_i.got.size() < exp_q.size() && n < 300) begin
      @(posedge clock);
      n++;
    end
    repeat (6) @(posedge clock);
    check("count", 239'(exp_q.size()), 239'(frag_sink_i.got.size()));
    while (exp_q.size() > 0 && frag_sink_i.got.size() > 0) begin
      e = exp_q.pop_front();
      g = frag_sink_i.got.pop_front();
      if (e[239]) check("command", 239'(e[238:234]), 239'(g[238:234]));
      else check("fragment", e[238:0], g);
    end
    exp_q.delete();
    frag_sink_i.got.delete();
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {read, write, in_valid, stall, slow, clamp, sgn, address, byteenable} = '0;
    {writedata, in_red, in_green, in_blue, in_alpha, in_kind, in_op, in_stream} = '0;
    {in_x, in_y, in_depth, in_index, in_color_src} = '0;
    rst_n = 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rd(4'h0, 32'h4);
    rd(4'h4, 32'h01000100);
    bus(1'b1, 4'h2, 32'hffffffff, 4'hf);
    rd(4'h2, 32'h0);
    send(2'h0, 3'h0, 2'h0, 16'h3, 16'h5, 2'h0, 32'h3f800000, 1'b1);
    send(2'h0, 3'h0, 2'h0, 16'h13, 16'h25, 2'h0, 32'h3f800000, 1'b1);
    send(2'h0, 3'h0, 2'h1, 16'hff, 16'hff, 2'h0, 32'h00000180, 1'b1);
    send(2'h0, 3'h0, 2'h0, 16'h100, 16'h0, 2'h0, 32'h0000017f, 1'b0);
    send(2'h0, 3'h0, 2'h0, 16'h0, 16'h100, 2'h0, 32'hffffff80, 1'b0);
    drain();
    rd(4'h8, 32'h2);
    // Stream filter with geometry shading on
    bus(1'b1, 4'h0, 32'h0c, 4'hf);
    for (i = 0; i < 4; i++) send(2'h0, 3'h0, 2'(i), 16'h7, 16'h9, 2'h0, 32'h1, i == 0);
    drain();
    rd(4'h8, 32'h5);
    bus(1'b1, 4'h8, 32'h0, 4'hf);
    rd(4'h8, 32'h0);
    // Color sources under clamping, unsigned then signed format
    bus(1'b1, 4'h0, 32'h06, 4'hf);
    clamp = 1'b1;
    for (i = 0; i < 8; i++) begin
      if (i == 4) bus(1'b1, 4'h0, 32'h16, 4'hf);
      sgn = (i > 3);
      send(2'h0, 3'h0, 2'h0, 16'h1, 16'h2, 2'(i), 32'hdeadbeef, 1'b1);
    end
    send(2'h0, 3'h0, 2'h0, 16'h1, 16'h2, 2'h1, 32'hffffff80, 1'b1);
    drain();
    // Discard on: primitive and listed commands vanish, others pass
    bus(1'b1, 4'h0, 32'h05, 4'hf);
    clamp = 1'b0;
    sgn = 1'b0;
    send(2'h0, 3'h0, 2'h0, 16'h4, 16'h4, 2'h0, 32'h2, 1'b0);
    for (i = 0; i < 8; i++) send(2'h1, 3'(i), 2'h0, 16'h0, 16'h0, 2'h0, 32'h0, i > 5);
    drain();
    rd(4'h8, 32'h00060001);
    bus(1'b1, 4'h0, 32'h04, 4'hf);
    for (i = 0; i < 8; i++) send(2'h1, 3'(i), 2'h0, 16'h0, 16'h0, 2'h0, 32'h0, 1'b1);
    send(2'h0, 3'h0, 2'h0, 16'h4, 16'h4, 2'h0, 32'h2, 1'b1);
    drain();
    // Width lane only; boundary column
    bus(1'b1, 4'h4, 32'hffff0040, 4'h3);
    rd(4'h4, 32'h01000040);
    send(2'h0, 3'h0, 2'h0, 16'h40, 16'h1, 2'h0, 32'h3, 1'b0);
    send(2'h0, 3'h0, 2'h0, 16'h3f, 16'hff, 2'h0, 32'h3, 1'b1);
    drain();
    // Fill buffer and output stage while stalled, then drain slowly
    stall <= 1'b1;
    for (i = 0; i < 9; i++) send(2'h0, 3'h0, 2'h0, 16'(i), 16'h2, 2'h0, 32'(i), 1'b1);
    repeat (3) @(posedge clock);
    rd(4'hc, 32'h88);
    stall <= 1'b0;
    slow <= 1'b1;
    drain();
    rd(4'hc, 32'h100);
    wrap_up();
  end
endmodule
`default_nettype wire
